// [design/nbbm_map.svh]
// constants of the bad-block and write-protect host controller
// assumes one 100 MHz clock and a x8 multiplexed flash bus
`ifndef NBBM_MAP_SVH
`define NBBM_MAP_SVH
`define NBBM_MARK_COL 12'd2048
`define NBBM_ERASED 8'hff
`define NBBM_ST_FAIL 0
`define NBBM_ST_RDY 6
`define NBBM_ST_WP 7
`define NBBM_CMD_READ0 8'h00
`define NBBM_CMD_READ1 8'h30
`define NBBM_CMD_STAT 8'h70
`define NBBM_CMD_ERS0 8'h60
`define NBBM_CMD_ERS1 8'hd0
`define NBBM_CMD_PRG0 8'h80
`define NBBM_CMD_PRG1 8'h10
`define NBBM_WP_NS 100
`define NBBM_CLK_NS 10
`define NBBM_WP_CYC ((`NBBM_WP_NS + `NBBM_CLK_NS - 1) / `NBBM_CLK_NS)
`define NBBM_STRB_CYC 3
`endif

// [design/nbbm_pkg.sv]
// types for the bad-block and write-protect host controller
// assumes nbbm_map.svh is on the include path
`default_nettype none
package nbbm_pkg;
  typedef enum logic [8:0] {
    NBBM_IDLE  = 9'h001,
    NBBM_CMD   = 9'h002,
    NBBM_ADDR  = 9'h004,
    NBBM_CMD2  = 9'h008,
    NBBM_WAIT  = 9'h010,
    NBBM_RDAT  = 9'h020,
    NBBM_STAT  = 9'h040,
    NBBM_WPHLD = 9'h080,
    NBBM_DONE  = 9'h100
  } nbbm_state_t;
  typedef enum logic [1:0] {
    NBBM_OP_SCAN = 2'h0,
    NBBM_OP_ERASE = 2'h1,
    NBBM_OP_PROG = 2'h2
  } nbbm_op_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] dq_o;
    logic dq_oe_n;
  } nbbm_pins_t;
endpackage : nbbm_pkg
`default_nettype wire

// [design/nbbm_ctrl.sv]
// host controller: factory bad-block scan, table, protected program/erase
// assumes a x8 flash on the pins; programs send no data bytes, the page fill is left to the flash
`include "nbbm_map.svh"
`default_nettype none
module nbbm_ctrl
  import nbbm_pkg::*;
#(
  parameter int BLOCKS = 1024,
  parameter int PAGES = 64
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic [1:0] OP,
  input wire logic [9:0] BLOCK,
  input wire logic [5:0] PAGE,
  input wire logic [7:0] DQ_I,
  input wire logic RB_N,
  output logic CLE,
  output logic ALE,
  output logic CE_N,
  output logic WE_N,
  output logic RE_N,
  output logic WP_N,
  output logic [7:0] DQ_O,
  output logic DQ_OE_N,
  output logic BUSY,
  output logic DONE,
  output logic FAIL,
  output logic REFUSED,
  output logic BAD_SEEN
);
  // port widths fit this geometry only
  if (BLOCKS != 1024 || PAGES != 64) begin : g_geom_chk
    $error("geometry unsupported");
  end

  typedef struct packed {
    nbbm_state_t st;
    nbbm_op_t op;
    logic [9:0] blk;
    logic [5:0] pg;
    logic [2:0] idx;
    logic [3:0] cnt;
    logic [7:0] cmd2;
    logic [7:0] dqs1;
    logic [7:0] dqs2;
    logic rbs1;
    logic rbs2;
    logic [BLOCKS-1:0] bad;
    logic [BLOCKS-1:0] scanned;
    nbbm_pins_t pins;
    logic busy;
    logic done;
    logic fail;
    logic refused;
    logic bad_seen;
  } nbbm_regs_t;

  nbbm_regs_t s_r;
  nbbm_regs_t s_nxt;

  // address byte: two column, two row bytes
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
    input logic [11:0] col, input logic [15:0] row);
    unique case (i)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {4'h0, col[11:8]};
      3'h2: addr_byte = row[7:0];
      default: addr_byte = row[15:8];
    endcase
  endfunction

  always_comb begin
    logic [11:0] col;
    logic [15:0] row;
    logic erase;
    s_nxt = s_r;
    erase = (s_r.op == NBBM_OP_ERASE);
    col = (s_r.op == NBBM_OP_SCAN) ? `NBBM_MARK_COL : 12'h000;
    row = {s_r.blk, s_r.pg};
    s_nxt.rbs1 = RB_N;
    s_nxt.rbs2 = s_r.rbs1;
    s_nxt.dqs1 = DQ_I;
    s_nxt.dqs2 = s_r.dqs1;
    s_nxt.done = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.pins.we_n = 1'b1;
    s_nxt.pins.re_n = 1'b1;
    if (s_r.cnt != 4'h0) begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    unique case (s_r.st)
      NBBM_IDLE: begin
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.pins.dq_oe_n = 1'b1;
        if (START) begin
          s_nxt.op = nbbm_op_t'(OP);
          s_nxt.blk = BLOCK;
          s_nxt.pg = (nbbm_op_t'(OP) == NBBM_OP_SCAN) ? 6'h00 : PAGE;
          s_nxt.fail = 1'b0;
          if (nbbm_op_t'(OP) == NBBM_OP_SCAN && BLOCK == 10'h000) begin
            s_nxt.scanned[0] = 1'b1;
            s_nxt.done = 1'b1;
          end else if (nbbm_op_t'(OP) != NBBM_OP_SCAN &&
                       (s_r.bad[BLOCK] || !s_r.scanned[BLOCK])) begin
            s_nxt.refused = 1'b1;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.busy = 1'b1;
            s_nxt.pins.wp_n = (nbbm_op_t'(OP) != NBBM_OP_SCAN);
            s_nxt.cnt = 4'(`NBBM_WP_CYC);
            s_nxt.st = NBBM_CMD;
          end
        end
      end
      NBBM_CMD: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.ce_n = 1'b0;
          s_nxt.pins.cle = 1'b1;
          s_nxt.pins.we_n = 1'b0;
          s_nxt.pins.dq_oe_n = 1'b0;
          s_nxt.pins.dq_o = erase ? `NBBM_CMD_ERS0 :
            (s_r.op == NBBM_OP_PROG) ? `NBBM_CMD_PRG0 : `NBBM_CMD_READ0;
          s_nxt.cmd2 = erase ? `NBBM_CMD_ERS1 :
            (s_r.op == NBBM_OP_PROG) ? `NBBM_CMD_PRG1 : `NBBM_CMD_READ1;
          s_nxt.idx = erase ? 3'h2 : 3'h0;
          s_nxt.cnt = 4'(`NBBM_STRB_CYC);
          s_nxt.st = NBBM_ADDR;
        end
      end
      NBBM_ADDR: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.cle = 1'b0;
          s_nxt.pins.ale = 1'b1;
          s_nxt.pins.we_n = 1'b0;
          s_nxt.pins.dq_o = addr_byte(s_r.idx, col, row);
          s_nxt.cnt = 4'(`NBBM_STRB_CYC);
          if (s_r.idx == 3'h3) begin
            s_nxt.st = NBBM_CMD2;
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
          end
        end
      end
      NBBM_CMD2: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.ale = 1'b0;
          s_nxt.pins.cle = 1'b1;
          s_nxt.pins.we_n = 1'b0;
          // program data phase kept minimal: page fill left to the flash
          s_nxt.pins.dq_o = s_r.cmd2;
          s_nxt.cnt = 4'hf;
          s_nxt.st = NBBM_WAIT;
        end
      end
      NBBM_WAIT: begin
        // hold latch and data one cycle past the rising write strobe
        if (s_r.cnt != 4'hf) begin
          s_nxt.pins.cle = 1'b0;
          s_nxt.pins.dq_oe_n = 1'b1;
        end
        // wait covers the write-to-busy delay before trusting ready
        if (s_r.cnt == 4'h0 && s_r.rbs2) begin
          s_nxt.cnt = 4'(`NBBM_STRB_CYC);
          if (s_r.op == NBBM_OP_SCAN) begin
            s_nxt.pins.re_n = 1'b0;
            s_nxt.st = NBBM_RDAT;
          end else begin
            s_nxt.pins.cle = 1'b1;
            s_nxt.pins.we_n = 1'b0;
            s_nxt.pins.dq_oe_n = 1'b0;
            s_nxt.pins.dq_o = `NBBM_CMD_STAT;
            s_nxt.idx = 3'h0;
            s_nxt.st = NBBM_STAT;
          end
        end
      end
      NBBM_RDAT: begin
        s_nxt.pins.re_n = (s_r.cnt == 4'h0) ? 1'b1 : 1'b0;
        if (s_r.cnt == 4'h0) begin
          // a mark on either page condemns the block
          if (s_r.dqs2 != `NBBM_ERASED) begin
            s_nxt.bad[s_r.blk] = 1'b1;
            s_nxt.bad_seen = 1'b1;
            s_nxt.scanned[s_r.blk] = 1'b1;
            s_nxt.st = NBBM_DONE;
          end else if (s_r.pg == 6'h00) begin
            s_nxt.pg = 6'h01;
            s_nxt.cnt = 4'(`NBBM_WP_CYC);
            s_nxt.st = NBBM_CMD;
          end else begin
            s_nxt.scanned[s_r.blk] = 1'b1;
            s_nxt.st = NBBM_DONE;
          end
        end
      end
      NBBM_STAT: begin
        if (s_r.cnt != 4'(`NBBM_STRB_CYC) || s_r.idx != 3'h0) begin
          s_nxt.pins.cle = 1'b0;
          s_nxt.pins.dq_oe_n = 1'b1;
        end
        if (s_r.cnt == 4'h0 && s_r.idx == 3'h0) begin
          s_nxt.pins.re_n = 1'b0;
          s_nxt.idx = 3'h1;
          s_nxt.cnt = 4'(`NBBM_STRB_CYC);
        end else if (s_r.cnt == 4'h0) begin
          // bit 7 low means the abort came from protection, not wear
          if (s_r.dqs2[`NBBM_ST_FAIL] && s_r.dqs2[`NBBM_ST_WP]) begin
            s_nxt.bad[s_r.blk] = 1'b1;
            s_nxt.bad_seen = 1'b1;
          end
          s_nxt.fail = s_r.dqs2[`NBBM_ST_FAIL];
          s_nxt.cnt = 4'(`NBBM_WP_CYC);
          s_nxt.st = NBBM_WPHLD;
        end else begin
          s_nxt.pins.re_n = s_r.pins.re_n;
        end
      end
      NBBM_WPHLD: begin
        s_nxt.pins.ce_n = 1'b1;
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.wp_n = 1'b0;
          s_nxt.st = NBBM_DONE;
        end
      end
      NBBM_DONE: begin
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = NBBM_IDLE;
      end
      default: begin
        s_nxt.st = NBBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.st <= NBBM_IDLE;
      s_r.pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
        re_n: 1'b1, wp_n: 1'b0, dq_o: 8'h00, dq_oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign CLE = s_r.pins.cle;
  assign ALE = s_r.pins.ale;
  assign CE_N = s_r.pins.ce_n;
  assign WE_N = s_r.pins.we_n;
  assign RE_N = s_r.pins.re_n;
  assign WP_N = s_r.pins.wp_n;
  assign DQ_O = s_r.pins.dq_o;
  assign DQ_OE_N = s_r.pins.dq_oe_n;
  assign BUSY = s_r.busy;
  assign DONE = s_r.done;
  assign FAIL = s_r.fail;
  assign REFUSED = s_r.refused;
  assign BAD_SEEN = s_r.bad_seen;
endmodule // nbbm_ctrl
`default_nettype wire

// [test/nbbm_sva.sv]
// port checks on the bad-block and write-protect controller
// assumes a bind into nbbm_ctrl and one clock domain
`default_nettype none
module nbbm_sva (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic [1:0] OP,
  input wire logic [9:0] BLOCK,
  input wire logic CLE,
  input wire logic ALE,
  input wire logic CE_N,
  input wire logic DQ_OE_N,
  input wire logic WE_N,
  input wire logic RE_N,
  input wire logic WP_N,
  input wire logic [7:0] DQ_O,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic FAIL,
  input wire logic REFUSED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  AST_WP_IDLE: assert property (!BUSY && !DONE |-> !WP_N)
    else $error("write protect released while idle");
  AST_WP_SETUP: assert property ($rose(WP_N) |-> WE_N [*8] ##1 WE_N [*2])
    else $error("write strobe too soon after unprotect");
  AST_WP_HOLD: assert property ($rose(RE_N) && WP_N |-> WP_N [*8])
    else $error("protect restored too soon");
  AST_PROT_CMD: assert property (CLE && !WE_N &&
    (DQ_O == 8'h60 || DQ_O == 8'h80) |-> WP_N)
    else $error("erase or program sent while protected");
  AST_COL: assert property (CLE && !WE_N && DQ_O == 8'h00 |->
    ##[1:8] (ALE && !WE_N && DQ_O == 8'h00)
    ##[1:8] (ALE && !WE_N && DQ_O == 8'h08))
    else $error("marker column not 2048");
  AST_STAT: assert property (CLE && !WE_N &&
    (DQ_O == 8'hd0 || DQ_O == 8'h10) |->
    ##[1:1000] (CLE && !WE_N && DQ_O == 8'h70))
    else $error("no status read after program or erase");
  AST_REFUSE: assert property (REFUSED |->
    DONE && $past(START) && $past(OP) != 2'h0)
    else $error("bad refusal");
  AST_FAIL_CLR: assert property ($rose(BUSY) |-> !FAIL)
    else $error("fail not cleared on start");
  AST_BLK0: assert property (START && !BUSY && !DONE && OP == 2'h0 &&
    BLOCK == 10'h000 |=> DONE && !BUSY)
    else $error("block zero scan touched the flash");
  AST_OE_READ: assert property (!RE_N |-> DQ_OE_N && !CE_N)
    else $error("bus driven or chip deselected during read");
  cover property (REFUSED);
  cover property ($rose(FAIL));
  cover property ($rose(WP_N));
endmodule // nbbm_sva
bind nbbm_ctrl nbbm_sva nbbm_sva_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .START(START), .OP(OP), .BLOCK(BLOCK), .CLE(CLE), .ALE(ALE),
  .CE_N(CE_N), .DQ_OE_N(DQ_OE_N),
  .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N), .DQ_O(DQ_O), .BUSY(BUSY),
  .DONE(DONE), .FAIL(FAIL), .REFUSED(REFUSED));
`default_nettype wire

// [test/nbbm_flash.sv]
// behavioural x8 flash: markers, status, ready/busy
// assumes strobes from nbbm_ctrl; latches on rising write strobe
`default_nettype none
module nbbm_flash (
  input wire logic CLE,
  input wire logic ALE,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic RE_N,
  input wire logic WP_N,
  input wire logic [7:0] DQ,
  output logic [7:0] DQ_I,
  output logic RB_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] adr = 32'h0;
  logic [7:0] cmd = 8'h0;
  logic [7:0] last = 8'h0;
  logic [9:0] blk = 10'h0;
  logic st = 1'b0;
  logic ab = 1'b0;
  wire [7:0] mark = ({adr[23:16], adr[31:24]} == 16'd2048 &&
    blk != 10'h000 &&
    ((adr[13:8] == 6'h00 && blk % 3 == 0) ||
    (adr[13:8] == 6'h01 && blk % 11 == 5)))
    ? 8'h00 : 8'hff;
  wire [7:0] out = cmd == 8'h70 ? {WP_N, RB_N, RB_N, 4'h0, st} : mark;
  initial RB_N = 1'b1;
  always @(posedge WE_N) if (!CE_N) begin
    if (ALE) adr = {adr[23:0], DQ};
    if (CLE) begin
      cmd = DQ;
      blk = {adr[7:0], adr[15:14]};
      if (DQ == 8'h30 || DQ == 8'hd0 || DQ == 8'h10) begin
        ab = 1'b0;
        st = DQ != 8'h30 && blk % 7 == 2;
        #50 RB_N = 1'b0;
        #($urandom_range(900, 200)) RB_N = 1'b1;
        st = st | ab;
      end
    end
  end
  // abort only counts while an operation is in flight
  always @(negedge WP_N) if (!RB_N) ab = 1'b1;
  always @(negedge RE_N) last = out;
  // released bus shows a changed value, never the stale byte
  assign DQ_I = (!RE_N && !CE_N) ? out : ~last;
endmodule // nbbm_flash
`default_nettype wire

// [test/nbbm_ctrl_tb.sv]
// self-checking bench for nbbm_ctrl
// assumes nbbm_flash as far side and the bound nbbm_sva checker
`default_nettype none
module nbbm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, start, rb_n, busy, done, fail, refused, bad_seen;
  logic cle, ale, ce_n, we_n, re_n, wp_n, dq_oe_n, got_ref, got_fail;
  logic [1:0] op;
  logic [9:0] blk, b;
  logic [5:0] page;
  logic [7:0] dq_i, dq_o;
  logic [1023:0] worn;
  int bad_count, n_checks;
  nbbm_ctrl nbbm_ctrl_inst (.REF_CLK(clk), .RST_N(rst_n), .START(start),
    .OP(op), .BLOCK(blk), .PAGE(page), .DQ_I(dq_i), .RB_N(rb_n),
    .CLE(cle), .ALE(ale), .CE_N(ce_n), .WE_N(we_n), .RE_N(re_n),
    .WP_N(wp_n), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .BUSY(busy),
    .DONE(done), .FAIL(fail), .REFUSED(refused), .BAD_SEEN(bad_seen));
  nbbm_flash nbbm_flash_inst (.CLE(cle), .ALE(ale), .CE_N(ce_n),
    .WE_N(we_n), .RE_N(re_n), .WP_N(wp_n), .DQ(dq_o), .DQ_I(dq_i),
    .RB_N(rb_n));
  function automatic logic exp_bad(input logic [9:0] x);
    return x != 10'h000 && (x % 3 == 0 || x % 11 == 5);
  endfunction
  function automatic logic exp_wear(input logic [9:0] x);
    return x % 7 == 2;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic seen, input logic ex);
    n_checks++;
    if (seen !== ex) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, ex, seen);
    end
  endtask
  task automatic run(input logic [1:0] o, input logic [9:0] x);
    int n;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    blk <= x;
    page <= x[5:0];
    n = 0;
    // a refusal answers one cycle after the start edge
    do begin
      @(posedge clk);
      start <= 1'b0;
      #1;
      n++;
    end while (done !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      bad_count++;
      summarize();
    end
    got_ref = refused;
    got_fail = fail;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    op = 2'h0;
    blk = 10'h000;
    page = 6'h00;
    bad_count = 0;
    n_checks = 0;
    worn = '0;
    void'($urandom(32'h4328));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(2'h1, 10'h007);
    check("refused unscanned", got_ref, 1'b1);
    run(2'h0, 10'h000);
    run(2'h2, 10'h000);
    check("refused block zero", got_ref, 1'b0);
    check("bad seen early", bad_seen, 1'b0);
    for (int i = 0; i < 24; i++) begin
      // first rounds: marked, worn, last block, page-one mark
      b = i == 0 ? 10'd3 : i == 1 ? 10'd2 : i == 2 ? 10'd1023
        : i == 3 ? 10'd5 : 10'($urandom_range(1023, 1));
      run(2'h0, b);
      run(i % 2 ? 2'h2 : 2'h1, b);
      check("refused marked", got_ref, exp_bad(b) | worn[b]);
      if (!exp_bad(b) && !worn[b])
        check("fail", got_fail, exp_wear(b));
      // repeated random blocks keep their wear from earlier rounds
      worn[b] = worn[b] | exp_wear(b);
      run(2'h1, b);
      check("refused again", got_ref, exp_bad(b) | exp_wear(b));
    end
    check("bad seen", bad_seen, 1'b1);
    summarize();
  end
endmodule // nbbm_ctrl_tb
`default_nettype wire
